// ==== rtl/sfd_ctrl.sv ====
// Supply fault, configuration latch, monitor select and debug control
`timescale 1ns/1ps
module sfd_ctrl (
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire logic        wake_i,
    input  wire logic [1:0]  volt_cfg_i,
    input  wire logic        debug_in_window_i,
    input  wire logic        debug_pin_low_i,
    input  wire logic        cca_ext_ballast_i,
    input  wire logic        aux_safety_i,
    input  wire logic        cca_safety_i,
    input  wire logic        aux_cmd_valid_i,
    input  wire logic        aux_cmd_on_i,
    input  wire logic        cca_cmd_valid_i,
    input  wire logic        cca_cmd_on_i,
    input  wire logic        aux_oc_i,
    input  wire logic        aux_ov_i,
    input  wire logic        cca_oc_i,
    input  wire logic        cca_ov_i,
    input  wire logic        can_ov_i,
    input  wire logic        flag_clr_i,
    input  wire logic        mux_wr_i,
    input  wire logic [2:0]  mux_sel_i,
    input  wire logic        wd_good_i,
    input  wire logic        wd_error_i,
    input  wire logic        fs_release_wr_i,
    input  wire logic        int_long_i,
    output logic             aux_en_o,
    output logic             cca_en_o,
    output logic             can_en_o,
    output logic [sfd_pkg::FLG_W-1:0] diag_flags_o,
    output logic [1:0]       volt_cfg_o,
    output logic [2:0]       mux_sel_o,
    output logic             failsafe_output_low_o,
    output logic             debug_mode_o,
    output logic             can_force_normal_o,
    output logic             wd_reset_req_o,
    output logic             por_req_o,
    output logic             interrupt_pulse_output_n_o
);
    localparam int FLG_W_L = sfd_pkg::FLG_W - 1;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    sfd_pkg::sfd_mode_t      mode_reg, mode_next;
    logic                    aux_reg, aux_next, cca_reg, cca_next;
    logic                    can_reg, can_next;
    logic [FLG_W_L:0]        flg_reg, flg_next, ev;
    logic [1:0]              cfg_reg, cfg_next;
    logic [2:0]              mux_reg, mux_next;
    logic                    fs_reg, fs_next, good_reg, good_next;
    logic                    rel_reg, rel_next, wdr_reg, wdr_next;
    logic                    por_reg, por_next;
    logic [15:0]             icnt_reg, icnt_next;

    always_comb begin
        ev = '0;
        ev[sfd_pkg::FLG_AUX_OC] = aux_oc_i;
        ev[sfd_pkg::FLG_AUX_OV] = aux_ov_i;
        ev[sfd_pkg::FLG_CCA_OC] = cca_oc_i & cca_ext_ballast_i;
        ev[sfd_pkg::FLG_CCA_OV] = cca_ov_i;
        ev[sfd_pkg::FLG_CAN_OV] = can_ov_i;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        mode_next = mode_reg;
        aux_next  = aux_reg;
        cca_next  = cca_reg;
        can_next  = can_reg;
        cfg_next  = cfg_reg;
        mux_next  = mux_reg;
        fs_next   = fs_reg;
        good_next = good_reg;
        rel_next  = rel_reg;
        wdr_next  = 1'b0;
        por_next  = 1'b0;
        // Set wins over clear so no fault slips past a clear
        flg_next  = (flag_clr_i ? '0 : flg_reg) | ev;
        if (aux_cmd_valid_i && !aux_safety_i) begin
            aux_next = aux_cmd_on_i;
        end
        if (cca_cmd_valid_i && !cca_safety_i) begin
            cca_next = cca_cmd_on_i;
        end
        if (ev[sfd_pkg::FLG_AUX_OC] || ev[sfd_pkg::FLG_AUX_OV]) begin
            aux_next = 1'b0;
        end
        if (ev[sfd_pkg::FLG_CCA_OC] || ev[sfd_pkg::FLG_CCA_OV]) begin
            cca_next = 1'b0;
        end
        if (can_ov_i) begin
            can_next = 1'b0;
        end
        if (mux_wr_i && mux_sel_i <= sfd_pkg::MUX_TEMP) begin
            mux_next = mux_sel_i;
        end
        if (wd_good_i) begin
            good_next = 1'b1;
        end
        case (mode_reg)
            sfd_pkg::ST_BOOT: begin
                // Strap is caught one clock after reset release
                cfg_next  = volt_cfg_i;
                fs_next   = 1'b1;
                mode_next = debug_in_window_i ? sfd_pkg::ST_DEBUG
                                              : sfd_pkg::ST_NORMAL;
            end
            sfd_pkg::ST_NORMAL: begin
                if (wake_i) begin
                    cfg_next  = volt_cfg_i;
                    fs_next   = 1'b1;
                    good_next = 1'b0;
                end else if (fs_release_wr_i && good_reg) begin
                    fs_next = 1'b0;
                end
                if (wd_error_i) begin
                    wdr_next = 1'b1;
                end
            end
            sfd_pkg::ST_DEBUG: begin
                // Watchdog errors are dropped here on purpose
                if (fs_release_wr_i && good_reg) begin
                    fs_next  = 1'b0;
                    rel_next = 1'b1;
                end
                if (rel_reg) begin
                    fs_next = 1'b0;
                end
                if (debug_pin_low_i) begin
                    por_next = 1'b1;
                end
            end
            default: mode_next = sfd_pkg::ST_BOOT;
        endcase
        if (|ev) begin
            icnt_next = int_long_i ? sfd_pkg::INT_LONG_CYC
                                   : sfd_pkg::INT_SHORT_CYC;
        end else if (icnt_reg != 16'h0000) begin
            icnt_next = icnt_reg - 16'h0001;
        end else begin
            icnt_next = icnt_reg;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            mode_reg <= sfd_pkg::ST_BOOT;
            aux_reg  <= 1'b1;
            cca_reg  <= 1'b1;
            can_reg  <= 1'b1;
            flg_reg  <= '0;
            cfg_reg  <= 2'h0;
            mux_reg  <= sfd_pkg::MUX_DEFAULT;
            fs_reg   <= 1'b1;
            good_reg <= 1'b0;
            rel_reg  <= 1'b0;
            wdr_reg  <= 1'b0;
            por_reg  <= 1'b0;
            icnt_reg <= 16'h0000;
        end else begin
            mode_reg <= mode_next;
            aux_reg  <= aux_next;
            cca_reg  <= cca_next;
            can_reg  <= can_next;
            flg_reg  <= flg_next;
            cfg_reg  <= cfg_next;
            mux_reg  <= mux_next;
            fs_reg   <= fs_next;
            good_reg <= good_next;
            rel_reg  <= rel_next;
            wdr_reg  <= wdr_next;
            por_reg  <= por_next;
            icnt_reg <= icnt_next;
        end
    end

    assign aux_en_o                   = aux_reg;
    assign cca_en_o                   = cca_reg;
    assign can_en_o                   = can_reg;
    assign diag_flags_o               = flg_reg;
    assign volt_cfg_o                 = cfg_reg;
    assign mux_sel_o                  = mux_reg;
    assign failsafe_output_low_o      = fs_reg;
    assign debug_mode_o               = (mode_reg == sfd_pkg::ST_DEBUG);
    assign can_force_normal_o         = debug_mode_o;
    assign wd_reset_req_o             = wdr_reg;
    assign por_req_o                  = por_reg;
    assign interrupt_pulse_output_n_o = (icnt_reg == 16'h0000);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    chk_aux_fault_off: assert property ((aux_oc_i | aux_ov_i) |=>
        !aux_en_o
        && (diag_flags_o[sfd_pkg::FLG_AUX_OC] || !$past(aux_oc_i))
        && (diag_flags_o[sfd_pkg::FLG_AUX_OV] || !$past(aux_ov_i)))
        else $error("sensor supply fault not handled");
    chk_debug_entry: assert property ((mode_reg == sfd_pkg::ST_BOOT)
        |=> debug_mode_o == $past(debug_in_window_i))
        else $error("debug entry does not follow the strap");
    chk_cca_fault_off: assert property (cca_ov_i |=> !cca_en_o)
        else $error("analog supply overvoltage not handled");
    chk_can_ov_off: assert property (can_ov_i |=> !can_en_o
        && diag_flags_o[sfd_pkg::FLG_CAN_OV])
        else $error("transceiver overvoltage not handled");
    chk_safety_hold: assert property ((aux_cmd_valid_i && aux_safety_i
        && !aux_oc_i && !aux_ov_i) |=> $stable(aux_en_o))
        else $error("safety critical supply switched");
    chk_int_pulse: assert property ((cca_ov_i && !int_long_i)
        |=> !interrupt_pulse_output_n_o [*8])
        else $error("interrupt pulse missing");
    chk_debug_wd_quiet: assert property (debug_mode_o |=>
        !wd_reset_req_o)
        else $error("watchdog error acted in debug mode");
    chk_rel_sticks: assert property ((debug_mode_o && rel_reg)
        |=> !failsafe_output_low_o)
        else $error("fail-safe reasserted in debug mode");
    chk_cfg_hold: assert property ((mode_reg == sfd_pkg::ST_NORMAL
        && !wake_i) |=> $stable(volt_cfg_o))
        else $error("voltage configuration changed");
    chk_can_normal: assert property (debug_mode_o
        |-> can_force_normal_o)
        else $error("transceiver not forced normal");

    cov_debug_entry: cover property (debug_mode_o
        ##[1:20] !failsafe_output_low_o);
    cov_wake: cover property (wake_i ##1 failsafe_output_low_o);
    cov_aux_off: cover property (aux_cmd_valid_i && !aux_cmd_on_i
        ##1 !aux_en_o);
    cov_exit: cover property (por_req_o);
endmodule : sfd_ctrl

// ==== rtl/sfd_pkg.sv ====
// Constants and types for the supply fault and debug control block
//
// Operation
// - Host command switches analog or sensor supply unless safety critical
// - Sensor supply overcurrent or overvoltage: off, flag, interrupt
// - Analog overvoltage, or overcurrent with external ballast, disables it
// - Analog and sensor supplies come up enabled after reset
// - Transceiver supply defaults on; overvoltage: off, flag, interrupt
// - Voltage configuration captured at power-on and wake-up, then held; debug mode ignores wake-up and keeps the power-on value
// - Latched analog and sensor voltage settings are readable by host
// - Debug mode entered only if debug pin in window at startup
// - Debug mode holds fail-safe output low at startup
// - In debug mode, after good answer and release write, fail-safe never reasserts
// - Debug mode ignores watchdog errors: no reset, no fail-safe
// - Debug mode forces transceiver into normal operating mode
// - Debug pin at ground leaves debug mode via full power-on reset
// - Host selects one of five monitor sources; device routes it
// - Fail-safe asserted after power-on and wake-up; host releases later
// - Interrupt condition emits low pulse of host-configured length
package sfd_pkg;
    // ------------------------------------------------------------------
    // Monitor source encoding
    // ------------------------------------------------------------------
    localparam logic [2:0] MUX_BATT     = 3'h0;
    localparam logic [2:0] MUX_PIN0     = 3'h1;
    localparam logic [2:0] MUX_PIN1     = 3'h2;
    localparam logic [2:0] MUX_VREF     = 3'h3;
    localparam logic [2:0] MUX_TEMP     = 3'h4;
    localparam logic [2:0] MUX_DEFAULT  = MUX_BATT;
    // ------------------------------------------------------------------
    // Diagnostic flag positions
    // ------------------------------------------------------------------
    localparam int FLG_AUX_OC  = 0;
    localparam int FLG_AUX_OV  = 1;
    localparam int FLG_CCA_OC  = 2;
    localparam int FLG_CCA_OV  = 3;
    localparam int FLG_CAN_OV  = 4;
    localparam int FLG_W       = 5;
    // ------------------------------------------------------------------
    // Interrupt pulse lengths
    // ------------------------------------------------------------------
    localparam int CLK_MHZ        = 100;
    localparam int INT_SHORT_US   = 25;
    localparam int INT_LONG_US    = 100;
    localparam logic [15:0] INT_SHORT_CYC = 16'(INT_SHORT_US * CLK_MHZ);
    localparam logic [15:0] INT_LONG_CYC  = 16'(INT_LONG_US * CLK_MHZ);
    typedef enum logic [1:0] {ST_BOOT, ST_NORMAL, ST_DEBUG} sfd_mode_t;
endpackage : sfd_pkg

// ==== tb/sfd_host_model.sv ====
// Host model: issues the host-side control pulses of the block
`timescale 1ns/1ps
module sfd_host_model (
    input  wire logic       mclk_i,
    output logic            aux_cmd_valid_o,
    output logic            aux_cmd_on_o,
    output logic            cca_cmd_valid_o,
    output logic            cca_cmd_on_o,
    output logic            mux_wr_o,
    output logic [2:0]      mux_sel_o,
    output logic            wd_good_o,
    output logic            wd_error_o,
    output logic            fs_release_wr_o,
    output logic            flag_clr_o,
    output logic            int_long_o
);
    // ------------------------------------------------------------------
    // Command issue
    // ------------------------------------------------------------------
    initial begin
        {aux_cmd_valid_o, aux_cmd_on_o, cca_cmd_valid_o, cca_cmd_on_o} = '0;
        {mux_wr_o, mux_sel_o, wd_good_o, wd_error_o} = '0;
        {fs_release_wr_o, flag_clr_o, int_long_o} = '0;
    end
    // Data fields are inverted once the strobe drops, so a stale value
    // can never pass for a fresh write
    task automatic send(input logic [3:0] op, input logic [2:0] arg);
        @(negedge mclk_i);
        case (op)
            4'h0: aux_cmd_valid_o = 1'b1;
            4'h1: cca_cmd_valid_o = 1'b1;
            4'h2: mux_wr_o = 1'b1;
            4'h3: wd_good_o = 1'b1;
            4'h4: wd_error_o = 1'b1;
            4'h5: fs_release_wr_o = 1'b1;
            4'h7: int_long_o = arg[0];
            default: flag_clr_o = 1'b1;
        endcase
        aux_cmd_on_o = arg[0];
        cca_cmd_on_o = arg[0];
        mux_sel_o = arg;
        @(negedge mclk_i);
        {aux_cmd_valid_o, cca_cmd_valid_o, mux_wr_o, wd_good_o} = '0;
        {wd_error_o, fs_release_wr_o, flag_clr_o} = '0;
        {aux_cmd_on_o, cca_cmd_on_o, mux_sel_o} = ~{arg[0], arg[0], arg};
    endtask : send
endmodule : sfd_host_model

// ==== tb/tb.sv ====
// Self-checking testbench for the supply fault and debug control block
`timescale 1ns/1ps
module tb;
    logic       mclk_i, reset_i, win, ballast, aux_safe, cca_safe;
    logic [6:0] pl;
    logic [1:0] cfg, cfg_o;
    logic       a_v, a_on, c_v, c_on, m_wr, good, wderr, rel, clr, ilong;
    logic [2:0] m_sel, mux_o;
    logic [4:0] flags;
    logic       aux_en, cca_en, can_en, fs_low, dbg, can_norm;
    logic       wd_rst, por, int_n;
    int         error_cnt, samples_checked, wd_base, por_base;
    int         low_cnt = 0, wd_cnt = 0, por_cnt = 0;
    // ------------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------------
    sfd_ctrl sfd_ctrl_i (.mclk_i(mclk_i), .reset_i(reset_i),
        .wake_i(pl[5]), .volt_cfg_i(cfg), .debug_in_window_i(win),
        .debug_pin_low_i(pl[6]), .cca_ext_ballast_i(ballast),
        .aux_safety_i(aux_safe), .cca_safety_i(cca_safe),
        .aux_cmd_valid_i(a_v), .aux_cmd_on_i(a_on), .cca_cmd_valid_i(c_v),
        .cca_cmd_on_i(c_on), .aux_oc_i(pl[0]), .aux_ov_i(pl[1]),
        .cca_oc_i(pl[2]), .cca_ov_i(pl[3]), .can_ov_i(pl[4]),
        .flag_clr_i(clr), .mux_wr_i(m_wr), .mux_sel_i(m_sel),
        .wd_good_i(good), .wd_error_i(wderr), .fs_release_wr_i(rel),
        .int_long_i(ilong), .aux_en_o(aux_en), .cca_en_o(cca_en),
        .can_en_o(can_en), .diag_flags_o(flags), .volt_cfg_o(cfg_o),
        .mux_sel_o(mux_o), .failsafe_output_low_o(fs_low),
        .debug_mode_o(dbg), .can_force_normal_o(can_norm),
        .wd_reset_req_o(wd_rst), .por_req_o(por),
        .interrupt_pulse_output_n_o(int_n));
    sfd_host_model host_i (.mclk_i(mclk_i), .aux_cmd_valid_o(a_v),
        .aux_cmd_on_o(a_on), .cca_cmd_valid_o(c_v), .cca_cmd_on_o(c_on),
        .mux_wr_o(m_wr), .mux_sel_o(m_sel), .wd_good_o(good),
        .wd_error_o(wderr), .fs_release_wr_o(rel), .flag_clr_o(clr),
        .int_long_o(ilong));
    // ------------------------------------------------------------------
    // Clock, monitors and tasks
    // ------------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        low_cnt <= low_cnt + int'(!int_n);
        wd_cnt <= wd_cnt + int'(wd_rst);
        por_cnt <= por_cnt + int'(por);
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic plant(input logic [6:0] v);
        @(negedge mclk_i);
        pl = v;
        @(negedge mclk_i);
        pl = 7'h00;
        repeat (2) @(negedge mclk_i);
    endtask : plant
    // Counts low cycles from before the fault, so the first ones count too
    task automatic int_len(input logic [6:0] v, input logic [15:0] exp);
        int base;
        base = low_cnt;
        plant(v);
        repeat (int'(exp) + 100) @(negedge mclk_i);
        chk(16'(low_cnt - base), exp);
    endtask : int_len
    task automatic do_reset(input logic w);
        @(negedge mclk_i);
        reset_i = 1'b1;
        win = w;
        repeat (8) @(negedge mclk_i);
        reset_i = 1'b0;
        repeat (2) @(negedge mclk_i);
    endtask : do_reset
    task automatic close_out();
        $display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out
    initial begin
        #400_000;
        error_cnt++;
        close_out();
    end
    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        reset_i = 1'b1;
        {win, ballast, aux_safe, cca_safe, pl} = '0;
        {error_cnt, samples_checked} = '0;
        cfg = 2'h2;
        do_reset(1'b0);
        chk({aux_en, cca_en, can_en}, 3'h7);
        chk(flags, 5'h00);
        chk(mux_o, sfd_pkg::MUX_DEFAULT);
        chk({fs_low, dbg, int_n}, 3'h5);
        chk(cfg_o, 2'h2);
        cfg = 2'h1;
        plant(7'h00);
        chk(cfg_o, 2'h2);
        for (int i = 0; i < 6; i++) begin
            host_i.send(4'h2, 3'(i));
            chk(mux_o, (i < 5) ? 3'(i) : sfd_pkg::MUX_TEMP);
        end
        host_i.send(4'h1, 3'h0);
        chk(cca_en, 1'b0);
        cca_safe = 1'b1;
        host_i.send(4'h1, 3'h1);
        chk(cca_en, 1'b0);
        aux_safe = 1'b1;
        host_i.send(4'h0, 3'h0);
        chk(aux_en, 1'b1);
        host_i.send(4'h5, 3'h0);
        wd_base = wd_cnt;
        host_i.send(4'h4, 3'h0);
        @(negedge mclk_i);
        chk({fs_low, 15'(wd_cnt - wd_base)}, 16'h8001);
        host_i.send(4'h3, 3'h0);
        host_i.send(4'h5, 3'h0);
        chk(fs_low, 1'b0);
        plant(7'h40);
        plant(7'h20);
        chk({fs_low, cfg_o, 2'(por_cnt)}, 5'h14);
        for (int k = 0; k < 5; k++) begin
            do_reset(1'b0);
            ballast = 1'b1;
            int_len(7'h01 << k, sfd_pkg::INT_SHORT_CYC);
            chk(flags, 5'h01 << k);
            chk({aux_en, cca_en, can_en},
                (k < 2) ? 3'h3 : (k < 4) ? 3'h5 : 3'h6);
        end
        host_i.send(4'h6, 3'h0);
        chk(flags, 5'h00);
        do_reset(1'b0);
        ballast = 1'b0;
        int_len(7'h04, 16'h0000);
        chk({cca_en, flags}, 6'h20);
        host_i.send(4'h7, 3'h1);
        int_len(7'h02, sfd_pkg::INT_LONG_CYC);
        do_reset(1'b1);
        chk({dbg, can_norm, fs_low}, 3'h7);
        wd_base = wd_cnt;
        host_i.send(4'h4, 3'h0);
        @(negedge mclk_i);
        chk({fs_low, 15'(wd_cnt - wd_base)}, 16'h8000);
        host_i.send(4'h3, 3'h0);
        host_i.send(4'h5, 3'h0);
        plant(7'h1b);
        chk(fs_low, 1'b0);
        por_base = por_cnt;
        plant(7'h40);
        chk(16'(por_cnt - por_base), 16'h0001);
        close_out();
    end
endmodule : tb
